/* File: bench/hbc_ctrl_model.sv */
// Controller model driving one bridge control pair
`timescale 1ns/1ps
`default_nettype none
module hbc_ctrl_model (
    input wire logic clock,
    input wire logic [1:0] pair,
    input wire logic [1:0] mode,
    output logic first,
    output logic second
);
    logic [7:0] cnt_q = 8'h00;
    logic f_q = 1'b0;
    logic s_q = 1'b0;
    logic pwm;
    assign pwm = cnt_q < 8'h80;
    assign first = f_q;
    assign second = s_q;
    always_ff @(posedge clock)
    begin
        cnt_q <= cnt_q + 8'h01;
        if (mode == 2'h1)
        begin
            f_q <= pwm;
            s_q <= 1'b0;
        end
        else if (mode == 2'h2)
        begin
            f_q <= 1'b1;
            s_q <= ~pwm;
        end
        else
        begin
            f_q <= pair[1];
            s_q <= pair[0];
        end
    end
endmodule
`default_nettype wire

/* File: bench/hbc_top_tb.sv */
// Self-checking bench for the dual bridge chopper
`timescale 1ns/1ps
`default_nettype none
module hbc_top_tb;
    import hbc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic slp_n = 1'b1;
    logic [1:0] pa = 2'h2;
    logic [1:0] pb = 2'h0;
    logic [1:0] md = 2'h0;
    logic ta = 1'b0;
    logic tb_t = 1'b0;
    logic oa = 1'b0;
    logic ob = 1'b0;
    wire ca1, ca2, cb1, cb2, al_out, al_oe;
    wire al_pin = al_oe ? al_out : 1'b1;
    wire [3:0] ga, gb;
    int errors = 0;
    int cmp_count = 0;
    int tick = 0;
    logic [3:0] exp_t [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
    always #4 clock = ~clock;
    hbc_ctrl_model hbc_ctrl_model_inst (.clock(clock), .pair(pa),
        .mode(md), .first(ca1), .second(ca2));
    hbc_ctrl_model hbc_ctrl_model_inst_b (.clock(clock), .pair(pb),
        .mode(md), .first(cb1), .second(cb2));
    hbc_top #(.WAKE_CYCLES(20), .RETRY_CYCLES(50)) hbc_top_inst (
        .clock(clock), .rst(rst), .low_power_request_n(slp_n),
        .bridge_a_ctrl_first(ca1), .bridge_a_ctrl_second(ca2),
        .bridge_b_ctrl_first(cb1), .bridge_b_ctrl_second(cb2),
        .bridge_a_winding_sense_trip(ta),
        .bridge_b_winding_sense_trip(tb_t),
        .bridge_a_overcurrent(oa), .bridge_b_overcurrent(ob),
        .protection_alarm_n_in(al_pin),
        .protection_alarm_n_out(al_out), .protection_alarm_n_oe(al_oe),
        .bridge_a_drive_first_high(ga[3]), .bridge_a_drive_first_low(ga[2]),
        .bridge_a_drive_second_high(ga[1]),
        .bridge_a_drive_second_low(ga[0]),
        .bridge_b_drive_first_high(gb[3]), .bridge_b_drive_first_low(gb[2]),
        .bridge_b_drive_second_high(gb[1]),
        .bridge_b_drive_second_low(gb[0]));
    task automatic chk(input string nm, input logic [3:0] e,
        input logic [3:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_wake();
        cyc(2);
        @(posedge clock) rst <= 1'b0;
        cyc(10);
        chk("waking", 4'h0, ga);
        cyc(80);
        chk("awake", 4'h9, ga);
    endtask
    task automatic t_table();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock) pa <= i[1:0];
            pb <= i[1:0];
            cyc(70);
            chk("pair a", exp_t[i], ga);
            chk("pair b", exp_t[i], gb);
        end
    endtask
    task automatic t_dead();
        @(posedge clock) pa <= 2'h2;
        pb <= 2'h2;
        cyc(30);
        chk("dead gap", 4'h1, ga);
        cyc(40);
        chk("after dead", 4'h9, ga);
    endtask
    task automatic t_chop();
        int n;
        @(posedge clock) pa <= 2'h0;
        cyc(70);
        @(posedge clock) pa <= 2'h2;
        cyc(10);
        @(posedge clock) ta <= 1'b1;
        cyc(290);
        chk("blanked", 4'h9, ga);
        cyc(400);
        chk("tripped", 4'h5, ga);
        chk("other bridge", 4'h9, gb);
        @(posedge clock) ta <= 1'b0;
        cyc(300);
        chk("held", 4'h5, ga);
        n = 0;
        while (ga[3] !== 1'b1 && n < 2500)
        begin
            cyc(1);
            n++;
        end
        chk("resumed", 4'h1, {3'h0, ga[3]});
        @(posedge clock) ta <= 1'b1;
        cyc(200);
        chk("min on", 4'h1, {3'h0, ga[3]});
        @(posedge clock) ta <= 1'b0;
        cyc(600);
    endtask
    task automatic t_ocp();
        @(posedge clock) oa <= 1'b1;
        ob <= 1'b1;
        cyc(300);
        @(posedge clock) ob <= 1'b0;
        cyc(219);
        chk("alarm on", 4'h1, {3'h0, al_oe});
        chk("a off", 4'h0, ga);
        chk("b runs", 4'h9, gb);
        @(posedge clock) oa <= 1'b0;
        cyc(130);
        chk("alarm off", 4'h0, {3'h0, al_oe});
        chk("a back", 4'h9, ga);
    endtask
    task automatic t_sleep();
        @(posedge clock) slp_n <= 1'b0;
        cyc(3);
        chk("sleep a", 4'h0, ga);
        chk("sleep b", 4'h0, gb);
        @(posedge clock) pa <= 2'h1;
        cyc(70);
        chk("ignored", 4'h0, ga);
        @(posedge clock) slp_n <= 1'b1;
        cyc(10);
        chk("rewake", 4'h0, ga);
        cyc(80);
        chk("reverse", exp_t[1], ga);
    endtask
    task automatic t_pwm();
        @(posedge clock) md <= 2'h1;
        cyc(2);
        while (ca1 !== 1'b0)
        begin
            cyc(1);
        end
        while (ca1 !== 1'b1)
        begin
            cyc(1);
        end
        cyc(100);
        chk("fast drive", 4'h9, ga);
        cyc(128);
        chk("fast coast", 4'h0, ga);
        @(posedge clock) md <= 2'h2;
        cyc(2);
        while (ca2 !== 1'b0)
        begin
            cyc(1);
        end
        while (ca2 !== 1'b1)
        begin
            cyc(1);
        end
        cyc(100);
        chk("slow brake", 4'h5, ga);
        cyc(128);
        chk("slow drive", 4'h9, ga);
        @(posedge clock) md <= 2'h0;
    endtask
    task automatic t_chop_b();
        @(posedge clock) tb_t <= 1'b1;
        cyc(300);
        chk("b blanked", 4'h9, gb);
        cyc(300);
        chk("b tripped", 4'h5, gb);
        chk("a untouched", exp_t[1], ga);
        @(posedge clock) tb_t <= 1'b0;
    endtask
    always @(posedge clock)
    begin
        tick++;
        if (tick == 9000)
        begin
            errors++;
            print_verdict();
        end
    end
    initial
    begin
        t_wake();
        t_table();
        t_dead();
        t_chop();
        t_ocp();
        t_pwm();
        t_sleep();
        t_chop_b();
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: pkg/hbc_pkg.sv */
// Shared constants and types for the dual bridge chopper
package hbc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int PWM_FREQ_KHZ = 50;
    localparam int PWM_CYC = CLK_MHZ * 1000 / PWM_FREQ_KHZ;
    localparam int BLANK_TIME_NS = 3750;
    localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_TIME_NS = 450;
    localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_TIME_MS = 1;
    localparam int WAKE_CYC = WAKE_TIME_MS * CLK_MHZ * 1000;
    localparam int OCP_RETRY_US = 1350;
    localparam int OCP_RETRY_CYC = OCP_RETRY_US * CLK_MHZ;
    localparam int OCP_DEGLITCH_US = 4;
    localparam int OCP_DEGLITCH_CYC = OCP_DEGLITCH_US * CLK_MHZ;
    localparam int PWM_W = 12;
    localparam int BLANK_W = 9;
    localparam int DEAD_W = 6;
    localparam int LONG_W = 18;

    typedef enum logic [1:0] {HBC_OFF, HBC_HIGH, HBC_LOW} hbc_half_t;
    typedef enum logic [1:0] {HBC_SLEEP, HBC_WAKING, HBC_RUN} hbc_mode_t;

    typedef struct packed {
        hbc_half_t lvl;
        logic [DEAD_W-1:0] dead;
    } hbc_half_st_t;
endpackage

/* File: rtl/hbc_dead_stage.sv */
// One half-bridge output stage with dead time
`timescale 1ns/1ps
`default_nettype none
module hbc_dead_stage
    import hbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clear,
    input wire hbc_half_t target,
    output logic gate_high,
    output logic gate_low
);
    hbc_half_st_t s_q;
    hbc_half_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (s_q.dead != '0)
        begin
            s_d.dead = s_q.dead - 1'b1;
        end
        if (target != s_q.lvl)
        begin
            if (s_q.lvl != HBC_OFF)
            begin
                s_d.lvl = HBC_OFF; // R10
                s_d.dead = DEAD_W'(DEAD_CYC); // R10
            end
            else if (s_q.dead == '0)
            begin
                s_d.lvl = target;
            end
        end
        if (clear)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign gate_high = (s_q.lvl == HBC_HIGH);
    assign gate_low = (s_q.lvl == HBC_LOW);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_no_overlap: assert property (!(gate_high && gate_low)) // R10
        else $error("Both switches of a half-bridge on");
    a_dead_gap: assert property ($fell(gate_high) |-> !gate_low [*8]) // R10
        else $error("Low switch on inside dead time");
endmodule
`default_nettype wire

/* File: rtl/hbc_top.sv */
// Dual H-bridge control with current chopping, sleep and retry
// Notes on behaviour
// [R01] Input pair selects coast, reverse, forward, brake
// [R02] Controller fast-decay PWM: other input low
// [R03] Controller slow-decay PWM: other input high
// [R04] Shared internal chop period at 50 kHz
// [R05] Sense trip stops drive until next period
// [R06] Sense ignored 3.75 us after drive starts
// [R07] Blanking sets minimum on-time per period
// [R08] Trip input is 200 mV comparator result
// [R09] After trip, both low sides on
// [R10] About 450 ns dead time between switches
// [R11] Bridges on within 1 ms of wake
// [R12] Sleep: outputs off, logic reset, inputs ignored
// [R13] Overcurrent disables bridge, alarm, then retries
// [R14] Per-bridge trip and blanking, period clears trip
`timescale 1ns/1ps
`default_nettype none
module hbc_top
    import hbc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int RETRY_CYCLES = OCP_RETRY_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic low_power_request_n,
    input wire logic bridge_a_ctrl_first,
    input wire logic bridge_a_ctrl_second,
    input wire logic bridge_b_ctrl_first,
    input wire logic bridge_b_ctrl_second,
    input wire logic bridge_a_winding_sense_trip,
    input wire logic bridge_b_winding_sense_trip,
    input wire logic bridge_a_overcurrent,
    input wire logic bridge_b_overcurrent,
    input wire logic protection_alarm_n_in,
    output logic protection_alarm_n_out,
    output logic protection_alarm_n_oe,
    output logic bridge_a_drive_first_high,
    output logic bridge_a_drive_first_low,
    output logic bridge_a_drive_second_high,
    output logic bridge_a_drive_second_low,
    output logic bridge_b_drive_first_high,
    output logic bridge_b_drive_first_low,
    output logic bridge_b_drive_second_high,
    output logic bridge_b_drive_second_low
);
    typedef struct packed {
        hbc_mode_t mode;
        logic [LONG_W-1:0] wake;
        logic [PWM_W-1:0] pwm;
        logic tick;
        logic [1:0] drv;
        logic [1:0] trip;
        logic [1:0] fault;
        logic [1:0][BLANK_W-1:0] blank;
        logic [1:0][BLANK_W-1:0] deg;
        logic [1:0][LONG_W-1:0] retry;
    } hbc_state_t;

    hbc_state_t s_q;
    hbc_state_t s_d;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [1:0] sense;
    logic [1:0] oc;
    logic run;
    hbc_half_t tgt [4];
    logic [3:0] g_hi;
    logic [3:0] g_lo;

    function automatic hbc_half_t decode_first(logic a, logic b);
        hbc_half_t r;
        r = HBC_OFF;
        if (a && !b)
        begin
            r = HBC_HIGH;
        end
        else if (b)
        begin
            r = HBC_LOW;
        end
        return r;
    endfunction

    assign c1 = {bridge_b_ctrl_first, bridge_a_ctrl_first};
    assign c2 = {bridge_b_ctrl_second, bridge_a_ctrl_second};
    assign sense = {bridge_b_winding_sense_trip, bridge_a_winding_sense_trip};
    assign oc = {bridge_b_overcurrent, bridge_a_overcurrent};
    assign run = (s_q.mode == HBC_RUN) && low_power_request_n; // R12

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        case (s_q.mode)
            HBC_SLEEP:
            begin
                s_d.mode = HBC_WAKING;
                s_d.wake = '0;
            end
            HBC_WAKING:
            begin
                s_d.wake = s_q.wake + 1'b1;
                if (s_q.wake == LONG_W'(WAKE_CYCLES - 1))
                begin
                    s_d.mode = HBC_RUN; // R11
                end
            end
            HBC_RUN:
            begin
                if (s_q.pwm == PWM_W'(PWM_CYC - 1))
                begin
                    s_d.pwm = '0; // R04
                    s_d.tick = 1'b1; // R04
                end
                else
                begin
                    s_d.pwm = s_q.pwm + 1'b1;
                end
            end
            default:
            begin
                s_d.mode = HBC_SLEEP;
            end
        endcase
        for (int b = 0; b < 2; b++)
        begin
            s_d.drv[b] = run && !s_q.fault[b] && (c1[b] ^ c2[b])
                && !s_q.trip[b];
            if (s_d.drv[b] && !s_q.drv[b])
            begin
                s_d.blank[b] = BLANK_W'(BLANK_CYC); // R06
            end
            else if (s_q.blank[b] != '0)
            begin
                s_d.blank[b] = s_q.blank[b] - 1'b1;
            end
            if (s_q.tick)
            begin
                s_d.trip[b] = 1'b0; // R14
            end
            else if (s_q.drv[b] && s_q.blank[b] == '0 && sense[b])
            begin
                s_d.trip[b] = 1'b1; // R05 R07 R08
            end
            if (s_q.fault[b])
            begin
                s_d.retry[b] = s_q.retry[b] + 1'b1;
                if (s_q.retry[b] == LONG_W'(RETRY_CYCLES - 1))
                begin
                    s_d.fault[b] = 1'b0; // R13
                    s_d.retry[b] = '0;
                    s_d.deg[b] = '0;
                end
            end
            else if (oc[b] && run)
            begin
                s_d.deg[b] = s_q.deg[b] + 1'b1;
                if (s_q.deg[b] == BLANK_W'(OCP_DEGLITCH_CYC - 1))
                begin
                    s_d.fault[b] = 1'b1; // R13
                end
            end
            else
            begin
                s_d.deg[b] = '0;
            end
        end
        if (!low_power_request_n)
        begin
            s_d = '0; // R12
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            tgt[2*b] = decode_first(c1[b], c2[b]); // R01
            tgt[2*b+1] = decode_first(c2[b], c1[b]); // R01
            if (s_q.trip[b] && (c1[b] ^ c2[b]))
            begin
                tgt[2*b] = HBC_LOW; // R09
                tgt[2*b+1] = HBC_LOW; // R09
            end
            if (!run || s_q.fault[b])
            begin
                tgt[2*b] = HBC_OFF; // R12 R13
                tgt[2*b+1] = HBC_OFF;
            end
        end
    end

    for (genvar i = 0; i < 4; i++)
    begin : g_stage
        hbc_dead_stage u_stage (
            .clock(clock),
            .rst(rst),
            .clear(!low_power_request_n),
            .target(tgt[i]),
            .gate_high(g_hi[i]),
            .gate_low(g_lo[i])
        );
    end

    assign bridge_a_drive_first_high = g_hi[0];
    assign bridge_a_drive_first_low = g_lo[0];
    assign bridge_a_drive_second_high = g_hi[1];
    assign bridge_a_drive_second_low = g_lo[1];
    assign bridge_b_drive_first_high = g_hi[2];
    assign bridge_b_drive_first_low = g_lo[2];
    assign bridge_b_drive_second_high = g_hi[3];
    assign bridge_b_drive_second_low = g_lo[3];
    assign protection_alarm_n_out = 1'b0;
    assign protection_alarm_n_oe = |s_q.fault; // R13

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_coast_off: assert property ( // R01
        !c1[0] && !c2[0] |=> g_hi[1:0] == 2'h0 && g_lo[1:0] == 2'h0)
        else $error("Coast did not release bridge a");
    a_sleep_off: assert property ( // R12
        !low_power_request_n |=> g_hi == 4'h0 && g_lo == 4'h0
        && s_q.mode == HBC_SLEEP)
        else $error("Sleep did not disable bridges");
    a_wake_entry: assert property ( // R11
        $rose(s_q.mode == HBC_RUN) |->
        $past(s_q.wake) == LONG_W'(WAKE_CYCLES - 1))
        else $error("Run entered at wrong wake count");
    a_period_tick: assert property ( // R04
        s_q.tick |-> s_q.pwm == '0
        && $past(s_q.pwm) == PWM_W'(PWM_CYC - 1))
        else $error("Period tick at wrong count");
    a_tick_clear: assert property (s_q.tick |=> s_q.trip == 2'h0) // R14
        else $error("Trip not cleared by period start");
    a_blank_hold: assert property ( // R06
        s_q.blank[0] != '0 && !s_q.trip[0] |=> !s_q.trip[0])
        else $error("Trip taken inside blanking");
    a_trip_decay: assert property ( // R09
        $rose(s_q.trip[0]) |-> ##[1:62]
        ((g_lo[1:0] == 2'h3) || !low_power_request_n || s_q.fault[0]
        || !(c1[0] ^ c2[0]) || s_q.tick))
        else $error("Trip did not reach slow decay");
    a_fault_off: assert property ( // R13
        s_q.fault[0] |-> protection_alarm_n_oe
        ##1 (g_hi[1:0] == 2'h0 && g_lo[1:0] == 2'h0))
        else $error("Faulted bridge still driving");

    c_trip: cover property ($rose(s_q.trip[0]));
    c_trip_b: cover property ($rose(s_q.trip[1]));
    c_fault_retry: cover property ($fell(s_q.fault[0]));
    c_wake: cover property ($rose(s_q.mode == HBC_RUN));
endmodule
`default_nettype wire
